// ### rsd_pkg.sv
// Constants, types and register map of the register subtract datapath
package rsd_pkg;

  // ------------------------------------------------------------
  // Datapath widths
  // ------------------------------------------------------------
  localparam int ACC_W    = 40;
  localparam int AUX_W    = 16;
  localparam int NAR_MSB  = 31;
  localparam int K4_W     = 4;
  localparam int CODE_W   = 4;
  localparam int RPT_W    = 8;
  localparam int N_ACC    = 4;
  localparam int N_AUX    = 12;
  localparam int AUX_CODE = 4;

  // ------------------------------------------------------------
  // Register map (byte addresses, low address byte decoded)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] CMD_OFS    = 8'h08;
  localparam logic [7:0] OPND_OFS   = 8'h0C;
  localparam logic [7:0] INSTR_OFS  = 8'h10;
  localparam logic [7:0] ACCLO_BASE = 8'h40;
  localparam logic [7:0] ACCHI_BASE = 8'h50;
  localparam logic [7:0] AUX_BASE   = 8'h80;
  localparam logic [7:0] AUX_LAST   = 8'hAC;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTL_SEXT  = 0;
  localparam int CTL_WIDE  = 1;
  localparam int CTL_DSAT  = 2;
  localparam int CTL_ASAT  = 3;
  localparam int CTL_LEG   = 4;
  localparam int ST_CARRY  = 0;
  localparam int ST_BUSY   = 1;
  localparam int ST_ACOV   = 4;
  localparam int CMD_FORM  = 0;
  localparam int CMD_DST   = 4;
  localparam int CMD_SRC   = 8;
  localparam int CMD_K4    = 12;
  localparam int CMD_RPT   = 16;
  localparam int INS_SRC   = 0;
  localparam int INS_DST   = 4;
  localparam int INS_IMM   = 8;
  localparam int INS_OPC   = 24;

  // Fixed first byte of the long immediate encoding
  localparam logic [7:0] LONG_IMM_OPC = 8'h7C;

  // ------------------------------------------------------------
  // Saturation bounds
  // ------------------------------------------------------------
  localparam logic [39:0] SAT_W_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT_W_NEG = 40'h80_0000_0000;
  localparam logic [39:0] SAT_N_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT_N_NEG = 40'hFF_8000_0000;
  localparam logic [15:0] SAT_A_POS = 16'h7FFF;
  localparam logic [15:0] SAT_A_NEG = 16'h8000;

  typedef enum logic [1:0] {FORM_REG, FORM_K4, FORM_K16, FORM_MEM} rsd_form_e;
  typedef enum logic {RUN_IDLE, RUN_EXEC} rsd_run_e;

  typedef struct packed {
    logic legacy;
    logic asat;
    logic dsat;
    logic wide;
    logic sext;
  } rsd_mode_s;

  typedef struct packed {
    rsd_form_e         form;
    logic [CODE_W-1:0] dst;
    logic [CODE_W-1:0] src;
    logic [K4_W-1:0]   k4;
    logic [AUX_W-1:0]  opnd;
    logic [RPT_W-1:0]  rpt;
  } rsd_cmd_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } rsd_dph_s;

endpackage

// ### rsd_addr_alu.sv
// 16-bit address-unit subtractor with overflow detect and saturation
`timescale 1ns/1ps
module rsd_addr_alu
  import rsd_pkg::*;
#(
  parameter int W = AUX_W
) (
  input  wire logic [W-1:0] opa_i,
  input  wire logic [W-1:0] opb_i,
  input  wire logic         sat_i,
  output logic      [W-1:0] res_o,
  output logic              ovf_o
);

  // ------------------------------------------------------------
  // Narrow subtraction
  // ------------------------------------------------------------
  logic [W-1:0] diff;

  // Wraps in W bits; overflow comes from sign of operands and result
  always_comb begin
    diff  = opa_i - opb_i;
    ovf_o = (opa_i[W-1] ^ opb_i[W-1]) & (opa_i[W-1] ^ diff[W-1]);
    res_o = diff;
    if (ovf_o && sat_i) begin
      // Direction follows the minuend sign: only it can be right
      res_o = opa_i[W-1] ? SAT_A_NEG : SAT_A_POS;
    end
  end

endmodule // rsd_addr_alu

// ### rsd_sub_core.sv
// Register subtract datapath with AHB-Lite register slave
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module rsd_sub_core
  import rsd_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             busy_o
);

  // ------------------------------------------------------------
  // Module state
  // ------------------------------------------------------------
  typedef struct packed {
    rsd_mode_s                    mode;
    logic                         carry;
    logic [N_ACC-1:0]             acov;
    rsd_run_e                     run;
    rsd_cmd_s                     cmd;
    logic [N_ACC-1:0][ACC_W-1:0]  acc;
    logic [N_AUX-1:0][AUX_W-1:0]  aux;
    rsd_dph_s                     dph;
    logic [31:0]                  rdata;
  } rsd_state_s;

  rsd_state_s st_reg;
  rsd_state_s st_next;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // True when a register code names an accumulator
  function automatic logic is_acc(input logic [CODE_W-1:0] code);
    is_acc = (code < CODE_W'(N_ACC));
  endfunction

  // Index of a 16-bit register within the auxiliary array
  function automatic logic [CODE_W-1:0] aux_idx(input logic [CODE_W-1:0] code);
    aux_idx = code - CODE_W'(AUX_CODE);
  endfunction

  // Widen a 16-bit word, sign or zero extension per mode
  function automatic logic [ACC_W-1:0] ext16(input logic [AUX_W-1:0] v,
                                             input logic sext);
    ext16 = {{(ACC_W-AUX_W){sext & v[AUX_W-1]}}, v};
  endfunction

  // Low 16 bits of any register
  function automatic logic [AUX_W-1:0] low16(input rsd_state_s s,
                                             input logic [CODE_W-1:0] code);
    if (is_acc(code)) begin
      low16 = s.acc[code[1:0]][AUX_W-1:0];
    end else begin
      low16 = s.aux[aux_idx(code)];
    end
  endfunction

  // Any register seen as a 40-bit data operand
  function automatic logic [ACC_W-1:0] full40(input rsd_state_s s,
                                              input logic [CODE_W-1:0] code);
    if (is_acc(code)) begin
      full40 = s.acc[code[1:0]];
    end else begin
      full40 = ext16(s.aux[aux_idx(code)], s.mode.sext);
    end
  endfunction

  // Slot of a 16-bit register in the bus map; the window base is word aligned,
  // so the word index fits the register code width without a wide index
  function automatic logic [CODE_W-1:0] aux_slot(input logic [7:0] a);
    logic [7:0] rel;
    rel      = a - AUX_BASE;
    aux_slot = rel[CODE_W+1:2];
  endfunction

  // ------------------------------------------------------------
  // Operand selection
  // ------------------------------------------------------------
  logic [CODE_W-1:0] a_code;
  logic              dst_acc;
  logic [ACC_W-1:0]  opa40;
  logic [ACC_W-1:0]  opb40;
  logic [AUX_W-1:0]  opa16;
  logic [AUX_W-1:0]  opb16;

  // Register and short forms take the destination as minuend
  always_comb begin
    dst_acc = is_acc(st_reg.cmd.dst);
    if (st_reg.cmd.form == FORM_REG || st_reg.cmd.form == FORM_K4) begin
      a_code = st_reg.cmd.dst;
    end else begin
      a_code = st_reg.cmd.src;
    end
    opa40 = full40(st_reg, a_code);
    opa16 = low16(st_reg, a_code);
    case (st_reg.cmd.form)
      FORM_REG: begin
        opb40 = full40(st_reg, st_reg.cmd.src);
        opb16 = low16(st_reg, st_reg.cmd.src);
      end
      FORM_K4: begin
        opb40 = ACC_W'(st_reg.cmd.k4);
        opb16 = AUX_W'(st_reg.cmd.k4);
      end
      FORM_K16: begin
        opb40 = ext16(st_reg.cmd.opnd, st_reg.mode.sext);
        opb16 = st_reg.cmd.opnd;
      end
      default: begin
        opb40 = ext16(st_reg.cmd.opnd, st_reg.mode.sext);
        opb16 = st_reg.cmd.opnd;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Data-unit subtractor, 40 bits
  // ------------------------------------------------------------
  logic [ACC_W:0]   diff41;
  logic [NAR_MSB+1:0] diff33;
  logic             ovf_w;
  logic             ovf_n;
  logic             acc_ovf;
  logic             acc_carry;
  logic [ACC_W-1:0] acc_res;

  // Both widths are formed; the mode picks which one reports
  always_comb begin
    diff41 = {1'b0, opa40} - {1'b0, opb40};
    diff33 = {1'b0, opa40[NAR_MSB:0]} - {1'b0, opb40[NAR_MSB:0]};
    ovf_w  = (opa40[ACC_W-1] ^ opb40[ACC_W-1]) &
             (opa40[ACC_W-1] ^ diff41[ACC_W-1]);
    ovf_n  = (opa40[NAR_MSB] ^ opb40[NAR_MSB]) &
             (opa40[NAR_MSB] ^ diff41[NAR_MSB]);
    if (st_reg.mode.wide) begin
      acc_ovf   = ovf_w;
      acc_carry = ~diff41[ACC_W];
    end else begin
      // Narrow reporting keeps results of the earlier generation
      acc_ovf   = ovf_n;
      acc_carry = ~diff33[NAR_MSB+1];
    end
    acc_res = diff41[ACC_W-1:0];
    if (acc_ovf && st_reg.mode.dsat) begin
      if (st_reg.mode.wide) begin
        acc_res = opa40[ACC_W-1] ? SAT_W_NEG : SAT_W_POS;
      end else begin
        acc_res = opa40[NAR_MSB] ? SAT_N_NEG : SAT_N_POS;
      end
    end
  end

  // ------------------------------------------------------------
  // Address-unit subtractor, 16 bits
  // ------------------------------------------------------------
  logic [AUX_W-1:0] aux_res;
  logic             aux_ovf;

  rsd_addr_alu #(
    .W (AUX_W)
  ) u_addr_alu (
    .opa_i (opa16),
    .opb_i (opb16),
    .sat_i (st_reg.mode.asat),
    .res_o (aux_res),
    .ovf_o (aux_ovf)
  );

  // ------------------------------------------------------------
  // Next-state logic: bus writes, execution, bus reads
  // ------------------------------------------------------------
  logic [N_ACC-1:0] acov_clr;
  logic [N_ACC-1:0] acov_set;
  logic [7:0]       wa;
  logic [7:0]       ra;
  logic [31:0]      wd;

  always_comb begin
    st_next  = st_reg;
    acov_clr = '0;
    acov_set = '0;
    wa       = st_reg.dph.addr;
    wd       = hwdata_i;
    ra       = haddr_i[7:0];

    // Data phase of a write; loading a command is refused while busy
    if (st_reg.dph.valid && st_reg.dph.write) begin
      if (wa == CTRL_OFS) begin
        st_next.mode.sext   = wd[CTL_SEXT];
        st_next.mode.wide   = wd[CTL_WIDE];
        st_next.mode.dsat   = wd[CTL_DSAT];
        st_next.mode.asat   = wd[CTL_ASAT];
        st_next.mode.legacy = wd[CTL_LEG];
      end else if (wa == STAT_OFS) begin
        acov_clr = wd[ST_ACOV +: N_ACC];
      end else if (wa == CMD_OFS && st_reg.run == RUN_IDLE) begin
        st_next.cmd.form = rsd_form_e'(wd[CMD_FORM +: 2]);
        st_next.cmd.dst  = wd[CMD_DST +: CODE_W];
        st_next.cmd.src  = wd[CMD_SRC +: CODE_W];
        st_next.cmd.k4   = wd[CMD_K4 +: K4_W];
        st_next.cmd.rpt  = wd[CMD_RPT +: RPT_W];
        st_next.run      = RUN_EXEC;
      end else if (wa == OPND_OFS && st_reg.run == RUN_IDLE) begin
        st_next.cmd.opnd = wd[AUX_W-1:0];
      end else if (wa == INSTR_OFS && st_reg.run == RUN_IDLE) begin
        // Only the long immediate encoding is accepted here
        if (wd[INS_OPC +: 8] == LONG_IMM_OPC) begin
          st_next.cmd.form = FORM_K16;
          st_next.cmd.opnd = wd[INS_IMM +: AUX_W];
          st_next.cmd.dst  = wd[INS_DST +: CODE_W];
          st_next.cmd.src  = wd[INS_SRC +: CODE_W];
          st_next.cmd.rpt  = '0;
          st_next.run      = RUN_EXEC;
        end
      end else if (st_reg.run == RUN_IDLE) begin
        // Register file writes; busy writes would race the datapath
        if (wa[7:4] == ACCLO_BASE[7:4]) begin
          st_next.acc[wa[3:2]][31:0] = wd;
        end else if (wa[7:4] == ACCHI_BASE[7:4]) begin
          st_next.acc[wa[3:2]][ACC_W-1:32] = wd[ACC_W-33:0];
        end else if (wa >= AUX_BASE && wa <= AUX_LAST) begin
          st_next.aux[aux_slot(wa)] = wd[AUX_W-1:0];
        end
      end
    end

    // One iteration per cycle; register and short forms re-read the updated destination
    case (st_reg.run)
      RUN_IDLE: begin
      end
      RUN_EXEC: begin
        if (dst_acc) begin
          st_next.acc[st_reg.cmd.dst[1:0]] = acc_res;
          st_next.carry = acc_carry;
          acov_set[st_reg.cmd.dst[1:0]] = acc_ovf;
        end else begin
          st_next.aux[aux_idx(st_reg.cmd.dst)] = aux_res;
        end
        if (st_reg.cmd.rpt == '0) begin
          st_next.run = RUN_IDLE;
        end else begin
          st_next.cmd.rpt = st_reg.cmd.rpt - RPT_W'(1);
        end
      end
      default: begin
        st_next.run = RUN_IDLE;
      end
    endcase

    // A new overflow beats a clear in the same cycle
    st_next.acov = (st_reg.acov & ~acov_clr) | acov_set;

    // Address phase capture; a read sees this cycle's updates
    st_next.dph.valid = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      st_next.dph.valid = 1'b1;
      st_next.dph.write = hwrite_i;
      st_next.dph.addr  = ra;
      if (!hwrite_i) begin
        st_next.rdata = '0;
        if (ra == CTRL_OFS) begin
          st_next.rdata[CTL_SEXT] = st_next.mode.sext;
          st_next.rdata[CTL_WIDE] = st_next.mode.wide;
          st_next.rdata[CTL_DSAT] = st_next.mode.dsat;
          st_next.rdata[CTL_ASAT] = st_next.mode.asat;
          st_next.rdata[CTL_LEG]  = st_next.mode.legacy;
        end else if (ra == STAT_OFS) begin
          st_next.rdata[ST_CARRY] = st_next.carry;
          st_next.rdata[ST_BUSY]  = (st_next.run == RUN_EXEC);
          st_next.rdata[ST_ACOV +: N_ACC] = st_next.acov;
        end else if (ra == CMD_OFS) begin
          st_next.rdata[CMD_FORM +: 2]    = st_next.cmd.form;
          st_next.rdata[CMD_DST +: CODE_W] = st_next.cmd.dst;
          st_next.rdata[CMD_SRC +: CODE_W] = st_next.cmd.src;
          st_next.rdata[CMD_K4 +: K4_W]   = st_next.cmd.k4;
          st_next.rdata[CMD_RPT +: RPT_W] = st_next.cmd.rpt;
        end else if (ra == OPND_OFS) begin
          st_next.rdata[AUX_W-1:0] = st_next.cmd.opnd;
        end else if (ra[7:4] == ACCLO_BASE[7:4]) begin
          st_next.rdata = st_next.acc[ra[3:2]][31:0];
        end else if (ra[7:4] == ACCHI_BASE[7:4]) begin
          st_next.rdata[ACC_W-33:0] = st_next.acc[ra[3:2]][ACC_W-1:32];
        end else if (ra >= AUX_BASE && ra <= AUX_LAST) begin
          st_next.rdata[AUX_W-1:0] = st_next.aux[aux_slot(ra)];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------

  // Whole state resets to zero, idle, nothing in flight
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // Zero-wait slave; every response OKAY, unmapped reads give zero
  assign hrdata_o    = st_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign busy_o      = (st_reg.run == RUN_EXEC);

endmodule // rsd_sub_core

// ### rsd_sub_checker.sv
// Port-level concurrent checks for the register subtract datapath
`timescale 1ns/1ps
module rsd_sub_checker
  import rsd_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        busy_o
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  logic       take;
  logic [7:0] ofs;
  logic       unmap;
  // Same qualifier and address byte as the slave decodes
  assign take  = hsel_i & hready_i & htrans_i[1];
  assign ofs   = haddr_i[7:0];
  assign unmap = (ofs > AUX_LAST) || (ofs > INSTR_OFS && ofs < ACCLO_BASE) ||
                 (ofs[7:4] > ACCHI_BASE[7:4] && ofs < AUX_BASE);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_ready_always: assert property (hreadyout_o)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp_o)
    else $error("hresp not OKAY");
  a_cmd_starts: assert property (
    (take && hwrite_i && ofs == CMD_OFS && !busy_o) ##1 !busy_o |=> busy_o)
    else $error("command write did not start execution");
  a_instr_starts: assert property (
    (take && hwrite_i && ofs == INSTR_OFS && !busy_o) ##1
    (!busy_o && hwdata_i[31:24] == LONG_IMM_OPC) |=> busy_o)
    else $error("long immediate word did not start");
  a_instr_refused: assert property (
    (take && hwrite_i && ofs == INSTR_OFS && !busy_o) ##1
    (!busy_o && hwdata_i[31:24] != LONG_IMM_OPC) |=> !busy_o)
    else $error("bad first byte started a run");
  a_busy_bounded: assert property ($rose(busy_o) |-> ##[1:257] !busy_o)
    else $error("busy held beyond maximum repeat");
  a_rdata_hold: assert property (!(take && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (take && !hwrite_i && unmap |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // rsd_sub_checker

bind rsd_sub_core rsd_sub_checker u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .busy_o(busy_o)
);

// ### tb.sv
// Self-checking testbench for the register subtract datapath
`timescale 1ns/1ps
module tb;
  import rsd_pkg::*;
  logic        clk_sys_i;
  logic        sys_rst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        busy;
  int          n_mismatch;
  int          checks;
  int          cycles = 0;

  rsd_sub_core dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .busy_o(busy)
  );

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Whole run is under three hundred cycles; a stuck handshake ends here
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Single AHB-Lite transfer; waits on hready rather than assuming latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0000_0000, rd);
    cmp({8'h00, rd}, {8'h00, exp});
  endtask
  // Accumulators are split over a low word and an 8-bit guard word
  task automatic set_acc(input logic [7:0] i, input logic [39:0] v);
    wr(ACCLO_BASE + (i << 2), v[31:0]);
    wr(ACCHI_BASE + (i << 2), {24'h00_0000, v[39:32]});
  endtask
  task automatic acc_chk(input logic [7:0] i, input logic [39:0] exp);
    logic [31:0] lo;
    logic [31:0] hi;
    xfer(1'b0, ACCLO_BASE + (i << 2), 32'h0000_0000, lo);
    xfer(1'b0, ACCHI_BASE + (i << 2), 32'h0000_0000, hi);
    cmp({hi[7:0], lo}, exp);
  endtask
  // Start a run and wait until busy clears; a refused start falls through
  task automatic run(input logic [31:0] w, input logic [7:0] a);
    wr(a, w);
    @(posedge clk_sys_i);
    while (busy === 1'b1) @(posedge clk_sys_i);
  endtask
  function automatic logic [31:0] cmd(input rsd_form_e f, input logic [3:0] d,
                                      input logic [3:0] s, input logic [3:0] k,
                                      input logic [7:0] r);
    return {8'h00, r, k, s, d, 2'b00, f};
  endfunction
  task automatic finish_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    sys_rst_i = 1'b1;
    n_mismatch = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd_chk(CTRL_OFS, 32'h0000_0000);
    rd_chk(STAT_OFS, 32'h0000_0000);
    acc_chk(8'h00, 40'h00_0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_001F);
    rd_chk(CTRL_OFS, 32'h0000_001F);
    $display("test reset done");
    wr(CTRL_OFS, 32'h0000_0002);
    set_acc(8'h00, 40'h00_0000_0005);
    set_acc(8'h01, 40'h00_0000_0007);
    run(cmd(FORM_REG, 4'h0, 4'h1, 4'h0, 8'h00), CMD_OFS);
    acc_chk(8'h00, 40'hFF_FFFF_FFFE);
    rd_chk(STAT_OFS, 32'h0000_0000);
    run(cmd(FORM_K4, 4'h1, 4'h0, 4'h7, 8'h00), CMD_OFS);
    acc_chk(8'h01, 40'h00_0000_0000);
    rd_chk(STAT_OFS, 32'h0000_0001);
    $display("test carry done");
    wr(CTRL_OFS, 32'h0000_0006);
    set_acc(8'h00, 40'h80_0000_0000);
    run(cmd(FORM_K4, 4'h0, 4'h0, 4'h1, 8'h00), CMD_OFS);
    acc_chk(8'h00, SAT_W_NEG);
    rd_chk(STAT_OFS, 32'h0000_0011);
    wr(STAT_OFS, 32'h0000_0010);
    rd_chk(STAT_OFS, 32'h0000_0001);
    $display("test saturate done");
    // Narrow pass runs with legacy mode on; only the overflow flag differs
    for (int w = 0; w < 2; w++) begin
      wr(CTRL_OFS, (w == 1) ? 32'h0000_0002 : 32'h0000_0010);
      wr(STAT_OFS, 32'h0000_00F0);
      set_acc(8'h00, 40'h00_8000_0000);
      run(cmd(FORM_K4, 4'h0, 4'h0, 4'h1, 8'h00), CMD_OFS);
      acc_chk(8'h00, 40'h00_7FFF_FFFF);
      rd_chk(STAT_OFS, (w == 1) ? 32'h0000_0001 : 32'h0000_0011);
    end
    $display("test width done");
    set_acc(8'h00, 40'h12_3456_0001);
    for (int s = 0; s < 2; s++) begin
      wr(CTRL_OFS, (s == 1) ? 32'h0000_0008 : 32'h0000_0000);
      wr(AUX_BASE + 8'h04, 32'h0000_8000);
      run(cmd(FORM_REG, 4'h5, 4'h0, 4'h0, 8'h00), CMD_OFS);
      rd_chk(AUX_BASE + 8'h04, (s == 1) ? 32'h0000_8000 : 32'h0000_7FFF);
    end
    wr(AUX_BASE, 32'h0000_0003);
    run(cmd(FORM_K4, 4'h4, 4'h0, 4'hF, 8'h00), CMD_OFS);
    rd_chk(AUX_BASE, 32'h0000_FFF4);
    rd_chk(STAT_OFS, 32'h0000_0001);
    $display("test aux done");
    for (int s = 0; s < 2; s++) begin
      wr(CTRL_OFS, s);
      wr(OPND_OFS, 32'h0000_FFFF);
      for (int f = 2; f < 4; f++) begin
        set_acc(8'h01, 40'h00_0000_0010);
        run(cmd(rsd_form_e'(f), 4'h0, 4'h1, 4'h0, 8'h00), CMD_OFS);
        acc_chk(8'h00, (s == 1) ? 40'h00_0000_0011 : 40'hFF_FFFF_0011);
      end
      wr(AUX_BASE, 32'h0000_8000);
      set_acc(8'h00, 40'h00_0000_0000);
      run(cmd(FORM_REG, 4'h0, 4'h4, 4'h0, 8'h00), CMD_OFS);
      acc_chk(8'h00, (s == 1) ? 40'h00_0000_8000 : 40'hFF_FFFF_8000);
    end
    $display("test extend done");
    wr(CTRL_OFS, 32'h0000_0002);
    set_acc(8'h01, 40'h00_0000_0010);
    run({LONG_IMM_OPC, 16'h0002, 4'h2, 4'h1}, INSTR_OFS);
    acc_chk(8'h02, 40'h00_0000_000E);
    run({8'h7D, 16'h0005, 4'h2, 4'h1}, INSTR_OFS);
    acc_chk(8'h02, 40'h00_0000_000E);
    $display("test encode done");
    wr(AUX_BASE + 8'h08, 32'h0000_0010);
    run(cmd(FORM_K4, 4'h6, 4'h0, 4'h3, 8'h04), CMD_OFS);
    rd_chk(AUX_BASE + 8'h08, 32'h0000_0001);
    set_acc(8'h03, 40'h00_0000_0005);
    run(cmd(FORM_K4, 4'h3, 4'h0, 4'h2, 8'h02), CMD_OFS);
    acc_chk(8'h03, 40'hFF_FFFF_FFFF);
    rd_chk(STAT_OFS, 32'h0000_0000);
    $display("test repeat done");
    finish_test();
  end
endmodule // tb
